// [cfes_defs.svh]
// Purpose: Constants for the clock fan-out enable sequencer
// Assumes: System clock of 20 MHz
// Notes: Times in their own units, cycle counts derived
`ifndef CFES_DEFS_SVH
`define CFES_DEFS_SVH
`define CFES_CLK_HZ 20000000
`define CFES_SETTLE_NS 1000
`define CFES_SETTLE_CYC ((`CFES_SETTLE_NS * (`CFES_CLK_HZ / 1000000) + 999) / 1000)
`define CFES_DISABLE_NS 10
`define CFES_CNT_W 8
`define CFES_DIV_W 4
`define CFES_DIFF_N 3
`define CFES_DIV_RATIO_DEF 4'h2
`endif

// [cfes_pkg.sv]
// Purpose: Types for the clock fan-out enable sequencer
// Assumes: Included constants header
// Notes: Sequencer states and output bundle
package cfes_pkg;
  typedef enum logic [1:0] {
    CFES_OFF = 2'b00,
    CFES_SETTLE = 2'b01,
    CFES_LOW = 2'b10,
    CFES_RUN = 2'b11
  } cfes_state_e;
  typedef struct packed {
    logic [2:0] diff_p;
    logic [2:0] diff_n;
    logic [2:0] diff_oe;
    logic se;
    logic se_oe;
  } cfes_out_s;
endpackage

// [cfes_seq.sv]
// Purpose: Output enable and reset sequencing of a clock fan-out buffer
// Assumes: Input clock sampled on mclk_i; enable and selects are pins
// Notes: Outputs are registered; undefined levels are modelled as low
// Function
// - Enable low puts all output drivers in high impedance
// - Mode selects ignored while disabled
// - Disable holds all flip-flops including divider in reset; the code keeps the pin and reference clock synchronisers sampling
// - After enable, settle about 1 us with true outputs high
// - Single-ended output level undefined during settle
// - After settle, outputs go low before clocks appear
// - Each output synchronised to input clock edges
// - Newly enabled stage starts undefined, complement is its inverse
// - First rising input edge: undivided output takes input level
// - Divided output shows present shared divider state
// - Per-output enable does not reset the divider
// - Outputs off within about 10 ns after latched low enable; the code takes one mclk cycle after en_s2_q falls, 50 ns at 20 MHz
`include "cfes_defs.svh"
module cfes_seq #(
  parameter int SETTLE_CYC = `CFES_SETTLE_CYC,
  parameter logic [`CFES_DIV_W-1:0] DIV_RATIO = `CFES_DIV_RATIO_DEF
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ref_clk_i,
  input wire logic dev_en_i,
  input wire logic [2:0] out_en_i,
  input wire logic [2:0] div_sel_i,
  input wire logic se_en_i,
  output logic [2:0] diff_p_o,
  output logic [2:0] diff_n_o,
  output logic [2:0] diff_oe_o,
  output logic single_ended_clock_output_o,
  output logic single_ended_clock_output_oe_o,
  output cfes_pkg::cfes_state_e state_o
);
  logic rst_s1_q, rst_n_q;
  logic clk_s1_q, clk_s2_q, clk_prev_q;
  logic en_s1_q, en_s2_q;
  logic [2:0] oen_s1_q, oen_s2_q, dsel_s1_q, dsel_s2_q;
  logic se_s1_q, se_s2_q;
  logic [`CFES_CNT_W-1:0] cnt_q;
  logic [`CFES_DIV_W-1:0] div_cnt_q;
  logic div_q;
  cfes_pkg::cfes_state_e st_q, st_d;
  cfes_pkg::cfes_out_s out_q, out_d;
  logic rise;
  logic [2:0] sel_en, dsel;
  logic sel_se;
  // Arming state per stage
  logic [2:0] arm_q;
  logic arm_se_q;

  // Reset release
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Reference clock synchroniser and edge history
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      clk_s1_q <= ref_clk_i;
      clk_s2_q <= clk_s1_q;
      clk_prev_q <= clk_s2_q;
    end
  end

  // Device enable synchroniser
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end
    else
    begin
      en_s1_q <= dev_en_i;
      en_s2_q <= en_s1_q;
    end
  end

  // Mode select synchronisers
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      oen_s1_q <= 3'h0;
      oen_s2_q <= 3'h0;
      dsel_s1_q <= 3'h0;
      dsel_s2_q <= 3'h0;
      se_s1_q <= 1'b0;
      se_s2_q <= 1'b0;
    end
    else
    begin
      oen_s1_q <= out_en_i;
      oen_s2_q <= oen_s1_q;
      dsel_s1_q <= div_sel_i;
      dsel_s2_q <= dsel_s1_q;
      se_s1_q <= se_en_i;
      se_s2_q <= se_s1_q;
    end
  end

  // Mode inputs pass only while running
  function automatic logic [2:0] gate_run(cfes_pkg::cfes_state_e st, logic [2:0] sel);
    gate_run = (st == cfes_pkg::CFES_RUN) ? sel : 3'h0;
  endfunction

  // Level an armed stage shows
  function automatic logic stage_level(logic divided, logic div_state, logic ref_level);
    stage_level = divided ? div_state : ref_level;
  endfunction

  assign rise = clk_s2_q & ~clk_prev_q;
  // Selects forced off unless running
  assign sel_en = gate_run(st_q, oen_s2_q);
  assign dsel = gate_run(st_q, dsel_s2_q);
  assign sel_se = |gate_run(st_q, {2'h0, se_s2_q});

  // Sequencer
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      cfes_pkg::CFES_OFF: if (en_s2_q) st_d = cfes_pkg::CFES_SETTLE;
      cfes_pkg::CFES_SETTLE:
        if (cnt_q == SETTLE_CYC[`CFES_CNT_W-1:0] - 8'h01) st_d = cfes_pkg::CFES_LOW;
      cfes_pkg::CFES_LOW: st_d = cfes_pkg::CFES_RUN;
      cfes_pkg::CFES_RUN: st_d = cfes_pkg::CFES_RUN;
      default: st_d = cfes_pkg::CFES_OFF;
    endcase
    if (!en_s2_q)
      st_d = cfes_pkg::CFES_OFF;
  end

  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      st_q <= cfes_pkg::CFES_OFF;
    else
      st_q <= st_d;
  end

  // Settle counter
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      cnt_q <= 8'h00;
    else if (st_q != cfes_pkg::CFES_SETTLE)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end

  // Shared divider, held in reset whenever the state is not running
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      div_cnt_q <= 4'h0;
      div_q <= 1'b0;
    end
    else if (st_q != cfes_pkg::CFES_RUN)
    begin
      div_cnt_q <= 4'h0;
      div_q <= 1'b0;
    end
    else if (rise)
    begin
      if (div_cnt_q >= DIV_RATIO - 4'h1)
      begin
        div_cnt_q <= 4'h0;
        div_q <= ~div_q;
      end
      else
        div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // Differential stage arming on first rising reference edge
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      arm_q <= 3'h0;
    else
    begin
      for (int i = 0; i < `CFES_DIFF_N; i++)
      begin
        if (!sel_en[i])
          arm_q[i] <= 1'b0;
        else if (rise)
          arm_q[i] <= 1'b1;
      end
    end
  end

  // Single-ended stage arming
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      arm_se_q <= 1'b0;
    else if (!sel_se)
      arm_se_q <= 1'b0;
    else if (rise)
      arm_se_q <= 1'b1;
  end

  // Output next values
  always_comb
  begin
    out_d = out_q;
    case (st_q)
      cfes_pkg::CFES_SETTLE:
      begin
        out_d.diff_p = 3'h7;
        out_d.diff_oe = 3'h7;
        out_d.se = 1'b0;
        out_d.se_oe = 1'b1;
      end
      cfes_pkg::CFES_LOW:
      begin
        out_d.diff_p = 3'h0;
        out_d.diff_oe = 3'h7;
        out_d.se = 1'b0;
        out_d.se_oe = 1'b1;
      end
      cfes_pkg::CFES_RUN:
      begin
        // Unarmed stages hold low until the first rising edge
        for (int i = 0; i < `CFES_DIFF_N; i++)
        begin
          if (!sel_en[i])
            out_d.diff_p[i] = 1'b0;
          else if (arm_q[i] || rise)
            out_d.diff_p[i] = stage_level(dsel[i], div_q, clk_s2_q);
          else
            out_d.diff_p[i] = 1'b0;
        end
        out_d.diff_oe = sel_en;
        if (sel_se && (arm_se_q || rise))
          out_d.se = div_q;
        else
          out_d.se = 1'b0;
        out_d.se_oe = sel_se;
      end
      default:
      begin
        out_d.diff_p = 3'h0;
        out_d.diff_oe = 3'h0;
        out_d.se = 1'b0;
        out_d.se_oe = 1'b0;
      end
    endcase
    out_d.diff_n = ~out_d.diff_p;
    // Disable overrides every drive enable
    if (!en_s2_q)
    begin
      out_d.diff_oe = 3'h0;
      out_d.se_oe = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      out_q <= '{diff_p: 3'h0, diff_n: 3'h7, diff_oe: 3'h0, se: 1'b0, se_oe: 1'b0};
    else
      out_q <= out_d;
  end

  // Status copy of state
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      state_o <= cfes_pkg::CFES_OFF;
    else
      state_o <= st_d;
  end

  assign diff_p_o = out_q.diff_p;
  assign diff_n_o = out_q.diff_n;
  assign diff_oe_o = out_q.diff_oe;
  assign single_ended_clock_output_o = out_q.se;
  assign single_ended_clock_output_oe_o = out_q.se_oe;
endmodule // cfes_seq

// [cfes_monitor.sv]
// Purpose: Checks on the enable sequencer ports
// Assumes: Bound into cfes_seq
// Notes: One clock domain
module cfes_monitor #(
  parameter int SETTLE_CYC = 20
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ref_clk_i,
  input wire logic dev_en_i,
  input wire logic [2:0] div_sel_i,
  input wire logic [2:0] diff_p_o,
  input wire logic [2:0] diff_n_o,
  input wire logic [2:0] diff_oe_o,
  input wire logic single_ended_clock_output_oe_o,
  input wire cfes_pkg::cfes_state_e state_o
);
  localparam int SMIN = SETTLE_CYC - 1;
  localparam int SMAX = SETTLE_CYC + 2;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_off_undriven: assert property (
    state_o == cfes_pkg::CFES_OFF |-> diff_oe_o == 3'h0) else $error("driven while off");
  a_se_off: assert property (
    state_o == cfes_pkg::CFES_OFF |-> !single_ended_clock_output_oe_o)
    else $error("single-ended driven while off");
  a_settle_high: assert property (
    state_o == cfes_pkg::CFES_SETTLE && $past(state_o) == cfes_pkg::CFES_SETTLE
    |-> diff_p_o == 3'h7 && diff_oe_o == 3'h7) else $error("settle not high");
  a_low_first: assert property (
    state_o == cfes_pkg::CFES_LOW |=> diff_p_o == 3'h0) else $error("no low step");
  a_comp_inverse: assert property (
    diff_n_o == ~diff_p_o) else $error("complement wrong");
  a_settle_len: assert property (
    $rose(state_o == cfes_pkg::CFES_SETTLE) |-> ##[SMIN:SMAX] state_o == cfes_pkg::CFES_LOW)
    else $error("settle length wrong");
  a_disable_fast: assert property (
    $fell(dev_en_i) |-> ##[1:4] diff_oe_o == 3'h0) else $error("slow disable");
  a_undiv_rise: assert property (
    $rose(ref_clk_i) && state_o == cfes_pkg::CFES_RUN && diff_oe_o[0] && !div_sel_i[0]
    |-> ##[1:4] diff_p_o[0]) else $error("undivided not high");
  a_undiv_fall: assert property (
    $fell(ref_clk_i) && state_o == cfes_pkg::CFES_RUN && diff_oe_o[0] && !div_sel_i[0]
    |-> ##[1:4] !diff_p_o[0]) else $error("undivided not low");
  c_settle: cover property (state_o == cfes_pkg::CFES_SETTLE);
  c_run: cover property (state_o == cfes_pkg::CFES_RUN);
  c_drop: cover property (state_o == cfes_pkg::CFES_RUN && !dev_en_i);
endmodule // cfes_monitor
bind cfes_seq cfes_monitor #(.SETTLE_CYC(SETTLE_CYC)) cfes_monitor_inst (.mclk_i, .rst_n_i,
  .ref_clk_i, .dev_en_i, .div_sel_i, .diff_p_o, .diff_n_o, .diff_oe_o,
  .single_ended_clock_output_oe_o, .state_o);

// [cfes_ref_src.sv]
// Purpose: Reference clock source model
// Assumes: Free running source
// Notes: Half period in mclk cycles
module cfes_ref_src #(
  parameter int HALF = 6
) (
  input wire logic mclk_i,
  output logic ref_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial ref_clk_o = 1'b0;
  // Edges away from the sampling edge
  always @(negedge mclk_i)
  begin
    cnt = (cnt + 1) % HALF;
    if (cnt == 0)
      ref_clk_o <= ~ref_clk_o;
  end
endmodule // cfes_ref_src

// [tb_cfes_seq.sv]
// Purpose: Testbench for the enable sequencer
// Assumes: Short settle of 3 cycles
// Notes: Inputs change on falling edges
module tb_cfes_seq;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, rst_n_i, ref_clk_i, dev_en_i, se_en_i, se_o, se_oe_o;
  logic [2:0] out_en_i, div_sel_i, diff_p_o, diff_n_o, diff_oe_o;
  cfes_pkg::cfes_state_e state_o;
  int error_cnt = 0;
  int tests_run = 0;
  cfes_seq #(.SETTLE_CYC(3)) cfes_seq_inst (.mclk_i, .rst_n_i, .ref_clk_i, .dev_en_i,
    .out_en_i, .div_sel_i, .se_en_i, .diff_p_o, .diff_n_o, .diff_oe_o, .state_o,
    .single_ended_clock_output_o(se_o), .single_ended_clock_output_oe_o(se_oe_o));
  cfes_ref_src cfes_ref_src_inst (.mclk_i, .ref_clk_o(ref_clk_i));
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(string name, logic [2:0] seen, logic [2:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_st(cfes_pkg::cfes_state_e s);
    int n;
    for (n = 0; state_o !== s; n++)
    begin
      if (n == 200)
      begin
        error_cnt++;
        give_verdict();
      end
      @(negedge mclk_i);
    end
  endtask
  task automatic wait_ref(logic lvl);
    int n;
    for (n = 0; ref_clk_i !== lvl; n++)
    begin
      if (n == 40)
      begin
        error_cnt++;
        give_verdict();
      end
      @(negedge mclk_i);
    end
  endtask
  task automatic t_up();
    dev_en_i = 1'b1;
    wait_st(cfes_pkg::CFES_SETTLE);
    @(negedge mclk_i);
    @(negedge mclk_i);
    check("settle p", diff_p_o, 3'h7);
    check("settle oe", diff_oe_o, 3'h7);
    wait_st(cfes_pkg::CFES_LOW);
    @(negedge mclk_i);
    check("low p", diff_p_o, 3'h0);
    wait_st(cfes_pkg::CFES_RUN);
    $display("t_up done");
  endtask
  task automatic t_undiv();
    wait_ref(1'b0);
    wait_ref(1'b1);
    repeat (4) @(negedge mclk_i);
    check("undiv high", {2'h0, diff_p_o[0]}, 3'h1);
    wait_ref(1'b0);
    repeat (4) @(negedge mclk_i);
    check("undiv low", {2'h0, diff_p_o[0]}, 3'h0);
    check("run oe", diff_oe_o, 3'h5);
    check("run se oe", {2'h0, se_oe_o}, 3'h1);
    $display("t_undiv done");
  endtask
  task automatic t_div();
    out_en_i = 3'h7;
    repeat (30) @(negedge mclk_i);
    repeat (12)
    begin
      @(negedge mclk_i);
      check("div", {2'h0, diff_p_o[1]}, {2'h0, diff_p_o[2]});
      check("comp", diff_n_o, ~diff_p_o);
      check("se div", {2'h0, se_o}, {2'h0, diff_p_o[2]});
    end
    $display("t_div done");
  endtask
  task automatic t_down();
    dev_en_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    check("off oe", diff_oe_o, 3'h0);
    check("off se oe", {2'h0, se_oe_o}, 3'h0);
    check("off st", {1'b0, state_o}, 3'h0);
    $display("t_down done");
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    dev_en_i = 1'b0;
    out_en_i = 3'h5;
    div_sel_i = 3'h6;
    se_en_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    check("reset oe", diff_oe_o, 3'h0);
    check("reset se oe", {2'h0, se_oe_o}, 3'h0);
    t_up();
    t_undiv();
    t_div();
    t_down();
    give_verdict();
  end
endmodule // tb_cfes_seq
